// *** bench/adx_add_exec_tb.sv ***
// Self-checking bench for the add execution unit over its AHB-Lite port.
// Assumes the unit is the only slave, so its hreadyout is fed back as hready.
module adx_add_exec_tb
  import adx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  assign hready = hreadyout;

  adx_add_exec DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));

  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // Hang guard, well above the roughly 400 cycles the tests need
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One single transfer; no wait-state count assumed, only hready is trusted
  task automatic bus_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus_xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_xfer(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd_chk

  function automatic logic [31:0] ra(input logic [15:0] off);
    return {16'h0, off};
  endfunction : ra

  function automatic logic [31:0] ma(input logic [11:0] ea);
    return 32'h4000 + {18'h0, ea, 2'h0};
  endfunction : ma

  // Expected STATUS after an 8-bit add: negative, overflow, zero, digit carry, carry in bits 4..0
  function automatic logic [31:0] exp_stat(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {27'h0, s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h0, h[4], s[8]};
  endfunction : exp_stat

  // Polls busy; a bounded number of polls keeps a stuck unit from hanging here
  task automatic exec(input logic [15:0] ins);
    logic [31:0] q;
    int n;
    wr(ra(ADX_OFF_INSTR), {16'h0, ins});
    n = 0;
    q = 32'h100;
    while (q[ADX_STAT_BUSY_BIT] !== 1'b0 && n < 10)
    begin
      bus_xfer(1'b0, ra(ADX_OFF_STATUS), 32'h0, q);
      n++;
    end
    check({31'h0, q[ADX_STAT_BUSY_BIT]}, 32'h0);
  endtask : exec

  task automatic file_case(input logic d, input logic a, input logic [7:0] f, input logic [11:0] ea,
                           input logic [7:0] acc, input logic [7:0] m);
    wr(ma(ea), {24'h0, m});
    wr(ra(ADX_OFF_ACC), {24'h0, acc});
    exec({ADX_OP_FILE, d, a, f});
    rd_chk(ra(ADX_OFF_ACC), {24'h0, d ? acc : acc + m});
    rd_chk(ma(ea), {24'h0, d ? acc + m : m});
    rd_chk(ra(ADX_OFF_STATUS), exp_stat(acc, m));
  endtask : file_case

  logic [7:0] ta [5] = '{8'h10, 8'hff, 8'h7f, 8'h80, 8'h08};
  logic [7:0] tk [5] = '{8'h15, 8'h01, 8'h01, 8'h80, 8'h08};

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Every register clears; unmapped places read zero and ignore writes
    for (int i = 0; i < 6; i++)
      rd_chk(32'(i * 4), 32'h0);
    wr(32'h18, 32'hff);
    rd_chk(32'h18, 32'h0);
    rd_chk(32'h0001_0000, 32'h0);
    check({31'h0, hresp}, 32'h0);
    check({31'h0, hreadyout}, 32'h1);
    $display("test reset done");
    // Corner sums: plain, wrap to zero, signed overflow both ways, half carry
    for (int i = 0; i < 5; i++)
    begin
      wr(ra(ADX_OFF_ACC), {24'h0, ta[i]});
      exec({ADX_OP_IMM, tk[i]});
      rd_chk(ra(ADX_OFF_ACC), {24'h0, ta[i] + tk[i]});
      rd_chk(ra(ADX_OFF_STATUS), exp_stat(ta[i], tk[i]));
    end
    $display("test immediate done");
    wr(ra(ADX_OFF_BANK), 32'h3);
    file_case(1'b0, 1'b1, 8'h25, 12'h325, 8'h17, 8'hc2);
    file_case(1'b1, 1'b1, 8'h25, 12'h325, 8'h17, 8'hc2);
    file_case(1'b1, 1'b1, 8'h40, 12'h340, 8'h90, 8'h90);
    file_case(1'b0, 1'b0, 8'h25, 12'h025, 8'h0f, 8'h01);
    file_case(1'b1, 1'b0, 8'ha0, 12'hfa0, 8'h80, 8'hff);
    $display("test file bank done");
    wr(ra(ADX_OFF_CTRL), 32'h1);
    wr(ra(ADX_OFF_INDEX), 32'h100);
    file_case(1'b0, 1'b0, 8'h5f, 12'h15f, 8'h33, 8'h44);
    file_case(1'b1, 1'b0, 8'h60, 12'hf60, 8'h01, 8'h7f);
    file_case(1'b1, 1'b1, 8'h10, 12'h310, 8'h02, 8'h03);
    wr(ra(ADX_OFF_INDEX), 32'hff0);
    file_case(1'b0, 1'b0, 8'h20, 12'h010, 8'h11, 8'h22);
    wr(ra(ADX_OFF_CTRL), 32'h0);
    $display("test indexed done");
    // Unknown opcode leaves the accumulator alone and raises the sticky flag
    wr(ra(ADX_OFF_STATUS), 32'h0);
    wr(ra(ADX_OFF_ACC), 32'h5);
    exec(16'h0b05);
    rd_chk(ra(ADX_OFF_ACC), 32'h5);
    rd_chk(ra(ADX_OFF_STATUS), 32'h200);
    wr(ra(ADX_OFF_STATUS), 32'h200);
    rd_chk(ra(ADX_OFF_STATUS), 32'h0);
    $display("test bad opcode done");
    // Back-to-back write lands while busy and is dropped; done four cycles on
    wr(ra(ADX_OFF_ACC), 32'h10);
    wr(ra(ADX_OFF_INSTR), {16'h0, ADX_OP_IMM, 8'h15});
    wr(ra(ADX_OFF_ACC), 32'h77);
    rd_chk(ra(ADX_OFF_STATUS), 32'h0);
    rd_chk(ra(ADX_OFF_ACC), 32'h25);
    rd_chk(ra(ADX_OFF_INSTR), 32'h0f15);
    $display("test busy done");
    // Reset in mid-run clears the registers again
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    check(hrdata, 32'h0);
    check({31'h0, hreadyout}, 32'h1);
    hresetn <= 1'b1;
    rd_chk(ra(ADX_OFF_ACC), 32'h0);
    rd_chk(ra(ADX_OFF_INSTR), 32'h0);
    rd_chk(ra(ADX_OFF_STATUS), 32'h0);
    $display("test reset again done");
    tally_and_finish();
  end

endmodule : adx_add_exec_tb

// *** core/adx_add_exec.sv ***
// Add execution unit: immediate and file-operand adds, with own data memory.
// Assumes one AHB-Lite master issuing single word transfers on hclk.
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.

// Operation
// - Immediate add opcode puts accumulator plus literal in accumulator, sets five flags.
// - File add opcode adds accumulator to addressed byte, sets five flags.
// - File add destination bit 0 writes accumulator, bit 1 writes the byte.
// - Extended mode, bank bit 0, address up to 5Fh uses indexed offset.
// - Bank bit 0 selects access bank, bit 1 uses bank select register.
module adx_add_exec
  import adx_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  adx_state_e state_reg, state_next;
  adx_instr_s dec;
  adx_sum_s sum_reg, sum_next;
  adx_flags_s flags_reg, flags_next;
  logic [7:0] acc_reg, acc_next;
  logic [7:0] operand_reg, operand_next;
  logic ext_reg, ext_next;
  logic bad_reg, bad_next;
  logic [3:0] bank_reg, bank_next;
  logic [11:0] index_reg, index_next;
  logic [11:0] eff_reg, eff_next;
  logic [15:0] ir_reg, ir_next;
  logic [7:0] mem [0:ADX_MEM_WORDS-1];
  logic mem_we;
  logic [11:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic wr_reg, wr_next;
  logic [15:0] waddr_reg, waddr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic take;
  logic addr_ok;
  logic busy;
  logic bus_wr;
  logic start;

  function automatic adx_instr_s adx_decode(input logic [15:0] w);
    adx_instr_s d;
    d.is_imm = (w[15:8] == ADX_OP_IMM);
    d.is_file = (w[15:10] == ADX_OP_FILE);
    d.dest = w[9];
    d.bank_bit = w[8];
    d.low = w[7:0];
    return d;
  endfunction : adx_decode

  function automatic logic [11:0] adx_file_addr(input logic [7:0] f, input logic a,
                                                input logic ext, input logic [3:0] bank,
                                                input logic [11:0] base);
    logic [11:0] r;
    if (a)
    begin
      r = {bank, f};
    end
    else if (ext && f <= ADX_INDEXED_MAX)
    begin
      r = base + {4'h0, f};
    end
    else if (f < ADX_ACCESS_SPLIT)
    begin
      r = {4'h0, f};
    end
    else
    begin
      r = {ADX_ACCESS_HIGH_BANK, f};
    end
    return r;
  endfunction : adx_file_addr

  function automatic adx_sum_s adx_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    adx_sum_s r;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    r.value = s[7:0];
    r.flags.c = s[8];
    r.flags.digit_carry_flag = h[4];
    r.flags.z = (s[7:0] == 8'h00);
    r.flags.n = s[7];
    r.flags.overflow_flag = (a[7] == b[7]) && (s[7] != a[7]);
    return r;
  endfunction : adx_add

  assign dec = adx_decode(ir_reg);
  assign busy = (state_reg != ST_IDLE);
  assign take = hsel && hready && htrans[1];
  assign addr_ok = (haddr[31:16] == 16'h0000) && (haddr[1:0] == 2'b00);
  // Zero wait states: data phase is always one cycle
  assign bus_wr = wr_reg && !busy;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // Bus address phase capture and read data
  always_comb
  begin
    wr_next = take && hwrite && addr_ok;
    waddr_next = waddr_reg;
    hrdata_next = hrdata_reg;
    if (take && hwrite)
    begin
      waddr_next = haddr[15:0];
    end
    if (take && !hwrite)
    begin
      hrdata_next = 32'h0000_0000;
      if (!addr_ok)
      begin
        hrdata_next = 32'h0000_0000;
      end
      else if (haddr[15:14] == ADX_MEM_SEL)
      begin
        hrdata_next = {24'h00_0000, mem[haddr[13:2]]};
      end
      else if (haddr[15:0] == ADX_OFF_CTRL)
      begin
        hrdata_next = {31'h0000_0000, ext_reg};
      end
      else if (haddr[15:0] == ADX_OFF_INSTR)
      begin
        hrdata_next = {16'h0000, ir_reg};
      end
      else if (haddr[15:0] == ADX_OFF_ACC)
      begin
        hrdata_next = {24'h00_0000, acc_reg};
      end
      else if (haddr[15:0] == ADX_OFF_STATUS)
      begin
        hrdata_next = {22'h0, bad_reg, busy, 3'h0, flags_reg};
      end
      else if (haddr[15:0] == ADX_OFF_BANK)
      begin
        hrdata_next = {28'h000_0000, bank_reg};
      end
      else if (haddr[15:0] == ADX_OFF_INDEX)
      begin
        hrdata_next = {20'h0_0000, index_reg};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_reg <= 1'b0;
      waddr_reg <= 16'h0000;
      hrdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wr_reg <= wr_next;
      waddr_reg <= waddr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // Software state and architectural results
  // Writes during an instruction are dropped so operands stay stable
  always_comb
  begin
    ext_next = ext_reg;
    bank_next = bank_reg;
    index_next = index_reg;
    acc_next = acc_reg;
    flags_next = flags_reg;
    bad_next = bad_reg;
    ir_next = ir_reg;
    start = 1'b0;
    if (bus_wr)
    begin
      if (waddr_reg == ADX_OFF_CTRL)
      begin
        ext_next = hwdata[ADX_CTRL_EXT_BIT];
      end
      else if (waddr_reg == ADX_OFF_INSTR)
      begin
        ir_next = hwdata[15:0];
        start = 1'b1;
      end
      else if (waddr_reg == ADX_OFF_ACC)
      begin
        acc_next = hwdata[7:0];
      end
      else if (waddr_reg == ADX_OFF_STATUS)
      begin
        flags_next = adx_flags_s'(hwdata[4:0]);
        if (hwdata[ADX_STAT_BAD_BIT])
        begin
          bad_next = 1'b0;
        end
      end
      else if (waddr_reg == ADX_OFF_BANK)
      begin
        bank_next = hwdata[3:0];
      end
      else if (waddr_reg == ADX_OFF_INDEX)
      begin
        index_next = hwdata[11:0];
      end
    end
    if (state_reg == ST_WRITE)
    begin
      flags_next = sum_reg.flags;
      if (dec.is_imm || !dec.dest)
      begin
        acc_next = sum_reg.value;
      end
    end
    // Set wins over a clear in the same cycle
    if (state_reg == ST_DECODE && !dec.is_imm && !dec.is_file)
    begin
      bad_next = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_reg <= 1'b0;
      bank_reg <= ADX_BANK_RST;
      index_reg <= ADX_INDEX_RST;
      acc_reg <= ADX_ACC_RST;
      flags_reg <= adx_flags_s'(5'h00);
      bad_reg <= 1'b0;
      ir_reg <= ADX_INSTR_RST;
    end
    else
    begin
      ext_reg <= ext_next;
      bank_reg <= bank_next;
      index_reg <= index_next;
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      bad_reg <= bad_next;
      ir_reg <= ir_next;
    end
  end

  // Quarter phase sequencer
  always_comb
  begin
    state_next = state_reg;
    operand_next = operand_reg;
    sum_next = sum_reg;
    eff_next = eff_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (start)
        begin
          state_next = ST_DECODE;
        end
      end
      ST_DECODE:
      begin
        eff_next = adx_file_addr(dec.low, dec.bank_bit, ext_reg, bank_reg, index_reg);
        state_next = (dec.is_imm || dec.is_file) ? ST_READ : ST_IDLE;
      end
      ST_READ:
      begin
        operand_next = dec.is_imm ? dec.low : mem[eff_reg];
        state_next = ST_PROC;
      end
      ST_PROC:
      begin
        sum_next = adx_add(acc_reg, operand_reg);
        state_next = ST_WRITE;
      end
      ST_WRITE:
      begin
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ST_IDLE;
      operand_reg <= 8'h00;
      sum_reg <= adx_sum_s'(13'h0000);
      eff_reg <= 12'h000;
    end
    else
    begin
      state_reg <= state_next;
      operand_reg <= operand_next;
      sum_reg <= sum_next;
      eff_reg <= eff_next;
    end
  end

  // Data memory write port, core write has priority
  always_comb
  begin
    mem_we = 1'b0;
    mem_waddr = waddr_reg[13:2];
    mem_wdata = hwdata[7:0];
    if (state_reg == ST_WRITE && dec.is_file && dec.dest)
    begin
      mem_we = 1'b1;
      mem_waddr = eff_reg;
      mem_wdata = sum_reg.value;
    end
    else if (bus_wr && waddr_reg[15:14] == ADX_MEM_SEL)
    begin
      mem_we = 1'b1;
    end
  end

  // Memory contents are not reset
  always_ff @(posedge hclk)
  begin
    if (mem_we)
    begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  property p_imm_sum;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_DECODE && dec.is_imm) |-> ##4
      (acc_reg == 8'($past(acc_reg, 4) + $past(ir_reg[7:0], 4)));
  endproperty
  a_imm_sum: assert property (p_imm_sum) else $error("immediate add result wrong");

  property p_imm_flags;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_DECODE && dec.is_imm) |-> ##4
      (flags_reg.c == ({1'b0, $past(acc_reg, 4)} + {1'b0, $past(ir_reg[7:0], 4)} > 9'h0ff))
      && (flags_reg.z == (acc_reg == 8'h00)) && (flags_reg.n == acc_reg[7]);
  endproperty
  a_imm_flags: assert property (p_imm_flags) else $error("immediate add flags wrong");

  property p_file_flags;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_PROC && dec.is_file) |=>
      (sum_reg.value == 8'(acc_reg + operand_reg)) ##1
      (flags_reg == $past(sum_reg.flags));
  endproperty
  a_file_flags: assert property (p_file_flags) else $error("file add sum or flags wrong");

  property p_dest;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_WRITE && dec.is_file) |->
      (mem_we == dec.dest) ##1 (acc_reg == ($past(dec.dest) ? $past(acc_reg) : $past(sum_reg.value)));
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");

  property p_indexed;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_DECODE && dec.is_file && !dec.bank_bit && ext_reg && dec.low <= ADX_INDEXED_MAX)
      |=> (eff_reg == 12'($past(index_reg) + {4'h0, $past(dec.low)}));
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed offset address wrong");

  property p_bank;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_DECODE && dec.is_file && (dec.bank_bit || !ext_reg)) |=>
      (eff_reg == ($past(dec.bank_bit) ? {$past(bank_reg), $past(dec.low)} :
       {($past(dec.low) < ADX_ACCESS_SPLIT) ? 4'h0 : ADX_ACCESS_HIGH_BANK, $past(dec.low)}));
  endproperty
  a_bank: assert property (p_bank) else $error("bank address wrong");

  property p_phases;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_IDLE && start) |=> (state_reg == ST_DECODE) ##1
      ((state_reg == ST_READ) ##1 (state_reg == ST_PROC) ##1 (state_reg == ST_WRITE) ##1
       (state_reg == ST_IDLE) or (state_reg == ST_IDLE && bad_reg));
  endproperty
  a_phases: assert property (p_phases) else $error("phase sequence wrong");

  property p_quiet;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_IDLE && !start) |=> $stable(acc_reg) || $past(bus_wr);
  endproperty
  a_quiet: assert property (p_quiet) else $error("accumulator changed while idle");

endmodule : adx_add_exec

// *** core/adx_pkg.sv ***
// Shared constants and types for the add execution unit.
// Assumes a 32-bit AHB-Lite slave port and 8-bit data memory bytes.
package adx_pkg;

  // Register byte offsets
  localparam logic [15:0] ADX_OFF_CTRL = 16'h0000;
  localparam logic [15:0] ADX_OFF_INSTR = 16'h0004;
  localparam logic [15:0] ADX_OFF_ACC = 16'h0008;
  localparam logic [15:0] ADX_OFF_STATUS = 16'h000c;
  localparam logic [15:0] ADX_OFF_BANK = 16'h0010;
  localparam logic [15:0] ADX_OFF_INDEX = 16'h0014;
  localparam logic [1:0] ADX_MEM_SEL = 2'h1;
  localparam int ADX_MEM_WORDS = 4096;

  // Field positions
  localparam int ADX_CTRL_EXT_BIT = 0;
  localparam int ADX_STAT_BUSY_BIT = 8;
  localparam int ADX_STAT_BAD_BIT = 9;

  // Reset values
  localparam logic [7:0] ADX_ACC_RST = 8'h00;
  localparam logic [3:0] ADX_BANK_RST = 4'h0;
  localparam logic [11:0] ADX_INDEX_RST = 12'h000;
  localparam logic [15:0] ADX_INSTR_RST = 16'h0000;

  // Opcodes and access bank split
  localparam logic [7:0] ADX_OP_IMM = 8'h0f;
  localparam logic [5:0] ADX_OP_FILE = 6'h09;
  localparam logic [7:0] ADX_INDEXED_MAX = 8'h5f;
  localparam logic [7:0] ADX_ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ADX_ACCESS_HIGH_BANK = 4'hf;

  // Cycles per instruction, one per quarter phase
  localparam int ADX_Q_PHASES = 4;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DECODE = 5'b00010,
    ST_READ = 5'b00100,
    ST_PROC = 5'b01000,
    ST_WRITE = 5'b10000
  } adx_state_e;

  typedef struct packed {
    logic n;
    logic overflow_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
  } adx_flags_s;

  typedef struct packed {
    logic is_imm;
    logic is_file;
    logic dest;
    logic bank_bit;
    logic [7:0] low;
  } adx_instr_s;

  typedef struct packed {
    logic [7:0] value;
    adx_flags_s flags;
  } adx_sum_s;

endpackage : adx_pkg
